// *** sim/earth_fault_front_model.sv ***
// Purpose: measurement front end model for the earth-fault stages
// Assumes: bench sets magnitude and angle targets on the rising edge
// Notes: projections follow from magnitude and angle
`timescale 1ns/1ps
module earth_fault_front_model
    import earth_fault_pkg::*;
(
    input wire logic [15:0] i_io,
    input wire logic [15:0] i_uo,
    input wire logic signed [9:0] i_phi,
    output meas_t o_meas
);
    real rad;
    always_comb begin
        rad = i_phi * 3.14159265 / 180.0;
        o_meas.io_mag = i_io;
        o_meas.uo_mag = i_uo;
        o_meas.phi = i_phi;
        o_meas.io_cos = 16'($rtoi(i_io * $cos(rad)));
        o_meas.io_sin = 16'($rtoi(i_io * $sin(rad)));
    end
endmodule

// *** sim/earth_fault_stages_bench.sv ***
// Purpose: self-checking bench for the earth-fault stage decisions
// Assumes: TICK_CYC of 20 cycles stands for 1 ms
// Notes: random angle stimulus plus directed timing and blocking cases
`timescale 1ns/1ps
`include "earth_fault_defines.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, got, exp); end end
module earth_fault_stages_bench import earth_fault_pkg::*;;
    localparam int TK = 20;
    logic i_sys_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [15:0] o_rdata;
    logic [15:0] io = 16'h0000;
    logic [15:0] uo = 16'h0000;
    logic [15:0] ic = 16'h0000;
    logic signed [9:0] phi = 10'h000;
    logic fwd = 1'b0;
    meas_t i_meas;
    stage_flags_t o_start;
    stage_flags_t o_trip;
    logic [1:0] o_start_code;
    logic calc_st;
    logic calc_act;
    logic [15:0] win;
    int check_count = 0;
    int bad_count = 0;
    int seed = 32'hd8a0_0018;

    always #2.5 i_sys_clk = ~i_sys_clk;

    earth_fault_front_model u_front (.i_io(io), .i_uo(uo), .i_phi(phi), .o_meas(i_meas));
    earth_fault_stages #(.TICK_CYC(TK)) u_dut (
        .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_meas(i_meas), .i_tr_ic_est(ic),
        .i_tr_fwd(fwd), .o_start(o_start), .o_trip(o_trip), .o_start_code(o_start_code),
        .o_tr_calc_start(calc_st), .o_tr_calc_active(calc_act), .o_integration_window(win)
    );

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        @(posedge i_sys_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        `CHK(o_rdata, e)
    endtask

    task automatic drive(input int i, input int u, input int p);
        @(posedge i_sys_clk);
        io <= 16'(i);
        uo <= 16'(u);
        phi <= 10'(p);
    endtask

    task automatic settle();
        repeat (2) @(posedge i_sys_clk);
        #1;
    endtask

    task automatic ms(input int n);
        repeat (n * TK) @(posedge i_sys_clk);
        #1;
    endtask

    task automatic done_test(input string n);
        $display("done %s checks %0d", n, check_count);
    endtask

    // Keeps random samples away from threshold and sector edges
    function automatic bit near(int i, int u, int p);
        real c;
        real s;
        int a;
        c = i * $cos(p * 3.14159265 / 180.0);
        s = i * $sin(p * 3.14159265 / 180.0);
        a = (p < 0) ? -p : p;
        return (u > 95 && u < 105) || (i > 95 && i < 105) || a < 4 || a > 176 ||
            (a > 76 && a < 84) || (a > 96 && a < 104) ||
            (c * c > 8100.0 && c * c < 12100.0) || (s * s > 8100.0 && s * s < 12100.0);
    endfunction

    function automatic logic exp_dir(meas_t m, charac_t c, hs_mode_t hm, int thr);
        int p;
        int pc;
        int ps;
        logic amp;
        p = m.phi;
        pc = m.io_cos;
        ps = m.io_sin;
        if (hm == HS_REV) begin
            p = (p > 0) ? p - 180 : p + 180;
            pc = -pc;
            ps = -ps;
        end
        amp = (m.io_mag > thr) && (m.uo_mag > thr);
        if (hm == HS_VOLT) return m.uo_mag > thr;
        if (hm == HS_NONDIR) return amp;
        case (c)
            CH_ANG0: return amp && p < (thr < 30 ? 70 : 80) && p > (thr < 30 ? -70 : -80);
            CH_ANG90: return amp && p < 0 && p > -180;
            CH_COS: return (m.uo_mag > thr) && pc >= thr;
            default: return (m.uo_mag > thr) && -ps >= thr;
        endcase
    endfunction

    initial begin
        #(70000 * 5);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        logic [7:0] ra[7];
        logic [15:0] re[7];
        int ri;
        int ru;
        int rp;
        int ch;
        logic el;
        logic eh;
        ra = '{`EF_ADDR_CTRL, `EF_ADDR_LS_I, `EF_ADDR_HS_I, `EF_ADDR_LS_T, `EF_ADDR_TR_T,
            `EF_ADDR_TR_INT, 8'h34};
        re = '{16'h0000, 16'h0064, 16'h0064, 16'h0064, 16'h1388, 16'h0012, 16'h0000};
        repeat (16) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        #1;
        `CHK({o_start, o_trip, calc_act, win}, {7'h00, 16'h0012})
        for (int k = 0; k < 7; k++) rd_chk(ra[k], re[k]);
        wr(`EF_ADDR_CTRL, 16'hFFFF);
        rd_chk(`EF_ADDR_CTRL, 16'h007F);
        wr(`EF_ADDR_TR_INT, 16'h0009);
        #1;
        `CHK(win, 16'h0009)
        done_test("registers");
        for (int k = 0; k < 6; k++) begin
            ch = (k < 4) ? k : 0;
            wr(`EF_ADDR_CTRL, 16'((k < 4) ? k * 8 + 36 : k * 32 - 60));
            repeat (25) begin
                do begin
                    ri = {$random(seed)} % 400;
                    ru = {$random(seed)} % 400;
                    rp = {$random(seed)} % 360 - 180;
                end while (near(ri, ru, rp));
                drive(ri, ru, rp);
                settle();
                el = exp_dir(i_meas, charac_t'(ch), HS_FWD, 100);
                eh = exp_dir(i_meas, charac_t'(ch), hs_mode_t'((k < 4) ? 1 : k - 2), 100);
                `CHK(o_start[1:0], {eh, el})
                `CHK(o_start_code, eh ? 2'd2 : {1'b0, el})
            end
        end
        done_test("characteristics");
        wr(`EF_ADDR_CTRL, 16'h0004);
        wr(`EF_ADDR_LS_I, 16'h0014);
        drive(200, 200, 75);
        settle();
        `CHK(o_start[1:0], 2'b10)
        drive(200, 200, 65);
        settle();
        `CHK(o_start[1:0], 2'b11)
        wr(`EF_ADDR_LS_I, 16'h0064);
        wr(`EF_ADDR_LS_T, 16'h0005);
        drive(200, 200, 0);
        ms(3);
        `CHK(o_trip.ls, 1'b0)
        drive(0, 200, 0);
        settle();
        `CHK({o_start.ls, o_trip.ls}, 2'b00)
        drive(200, 200, 0);
        ms(3);
        `CHK(o_trip.ls, 1'b0)
        ms(3);
        `CHK(o_trip.ls, 1'b1)
        drive(0, 0, 0);
        done_test("directional timing");
        wr(`EF_ADDR_CTRL, 16'h0000);
        wr(`EF_ADDR_TR_TRIG, 16'h0032);
        wr(`EF_ADDR_TR_HOLD, 16'h0028);
        wr(`EF_ADDR_TR_IC, 16'h001E);
        wr(`EF_ADDR_TR_T, 16'h000A);
        fwd <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            drive(0, 20, 0);
            ic <= (k == 1) ? 16'h0009 : 16'h000A;
            drive(0, 200, 0);
            @(posedge i_sys_clk);
            #1;
            `CHK({o_start.tr, calc_st, calc_act}, 3'b111)
            @(posedge i_sys_clk);
            #1;
            `CHK(calc_st, 1'b0)
            if (k == 2) drive(0, 30, 0);
            ms(8);
            `CHK(o_trip.tr, 1'b0)
            ms(4);
            `CHK({o_start.tr, o_trip.tr}, {1'b0, k == 0})
            drive(0, 20, 0);
            settle();
            `CHK(o_trip.tr, 1'b0)
        end
        wr(`EF_ADDR_CTRL, 16'h0004);
        drive(0, 200, 0);
        settle();
        `CHK({o_start.tr, calc_act}, 2'b00)
        done_test("transient");
        wr(`EF_ADDR_CTRL, 16'h0061);
        wr(`EF_ADDR_HS_T, 16'h0002);
        wr(`EF_ADDR_TR_T, 16'h0258);
        drive(200, 20, 0);
        drive(200, 200, 0);
        settle();
        `CHK(o_start[1:0], 2'b10)
        ms(396);
        `CHK({o_trip[1:0], calc_act}, 3'b001)
        ms(8);
        `CHK({o_trip[1:0], calc_act}, 3'b100)
        // Park the transient stage so the next case starts from idle
        wr(`EF_ADDR_CTRL, 16'h0004);
        wr(`EF_ADDR_CTRL, 16'h0002);
        wr(`EF_ADDR_TR_T, 16'h04B0);
        drive(200, 20, 0);
        drive(200, 200, 0);
        ms(995);
        `CHK({o_trip[1:0], calc_act}, 3'b001)
        rd_chk(`EF_ADDR_STATUS, 16'h00C7);
        ms(10);
        `CHK({o_trip[1:0], calc_act}, 3'b110)
        wr(`EF_ADDR_CTRL, 16'h0004);
        wr(`EF_ADDR_CTRL, 16'h0000);
        wr(`EF_ADDR_LS_T, 16'h012C);
        wr(`EF_ADDR_HS_T, 16'h0064);
        drive(200, 20, 0);
        drive(200, 200, 0);
        ms(103);
        `CHK(o_trip[1:0], 2'b10)
        ms(1090);
        `CHK({o_trip[1:0], calc_act}, 3'b001)
        ms(12);
        `CHK({o_trip[1:0], calc_act}, 3'b110)
        done_test("blocking");
        tally_and_finish();
    end
endmodule

// *** verilog/earth_fault_defines.svh ***
// Purpose: constants for the earth-fault stage decision block
// Assumes: 200 MHz system clock, settings in ms, 0.1 %, degrees
// Notes: register offsets are byte addresses on the plain port
`ifndef EARTH_FAULT_DEFINES_SVH
`define EARTH_FAULT_DEFINES_SVH
`define EF_ADDR_CTRL 8'h00
`define EF_ADDR_LS_I 8'h04
`define EF_ADDR_LS_U 8'h08
`define EF_ADDR_LS_T 8'h0C
`define EF_ADDR_HS_I 8'h10
`define EF_ADDR_HS_U 8'h14
`define EF_ADDR_HS_T 8'h18
`define EF_ADDR_TR_TRIG 8'h1C
`define EF_ADDR_TR_HOLD 8'h20
`define EF_ADDR_TR_IC 8'h24
`define EF_ADDR_TR_T 8'h28
`define EF_ADDR_TR_INT 8'h2C
`define EF_ADDR_STATUS 8'h30
`define EF_CTRL_LSDIS 0
`define EF_CTRL_SPEEDUP 1
`define EF_CTRL_TRDIS 2
`define EF_CTRL_CHAR_LO 3
`define EF_CTRL_HSMODE_LO 5
`define EF_CTRL_RESET 16'h0000
`define EF_TIME_RESET 16'h0064
`define EF_THR_RESET 16'h0064
`define EF_TR_TIME_RESET 16'h1388
`define EF_INT_RESET 16'h0012
`define EF_CLK_HZ 200000000
`define EF_TICK_MS 1
`define EF_HS_BLOCK_MS 400
`define EF_SPEEDUP_BLOCK_MS 1000
`define EF_TR_GUARD_MS 1000
`define EF_SECTOR_NARROW 70
`define EF_SECTOR_WIDE 80
`define EF_SECTOR_LIMIT 30
`define EF_IC_DIVISOR 3
`endif

// *** verilog/earth_fault_pkg.sv ***
// Purpose: types for the earth-fault stage decision block
// Assumes: measurements arrive on the system clock
// Notes: angles are signed degrees, projections signed
package earth_fault_pkg;
    typedef enum logic [1:0] {
        CH_ANG0 = 2'b00,
        CH_ANG90 = 2'b01,
        CH_COS = 2'b10,
        CH_SIN = 2'b11
    } charac_t;
    typedef enum logic [1:0] {
        HS_FWD = 2'b00,
        HS_REV = 2'b01,
        HS_NONDIR = 2'b10,
        HS_VOLT = 2'b11
    } hs_mode_t;
    typedef enum logic [2:0] {
        TR_IDLE = 3'b001,
        TR_RUN = 3'b010,
        TR_TRIP = 3'b100
    } tr_state_t;
    typedef struct packed {
        logic [15:0] io_mag;
        logic [15:0] uo_mag;
        logic signed [9:0] phi;
        logic signed [15:0] io_cos;
        logic signed [15:0] io_sin;
    } meas_t;
    typedef struct packed {
        logic tr;
        logic hs;
        logic ls;
    } stage_flags_t;
endpackage

// *** verilog/earth_fault_stages.sv ***
// Purpose: start and trip decisions of low-set, high-set and transient stages
// Assumes: measurement and transient front end run on i_sys_clk
// Notes: settings and status over a plain register port
//
// Overview of operation
// - Two independent directional stages, low-set and high-set, with own settings.
// - Angle criterion: current and voltage above threshold, angle inside area.
// - Projection criterion: voltage and current times sine or cosine.
// - Characteristic: sine, cosine, or angle around 0 or -90 degrees.
// - Low-set always forward; high-set forward or reverse.
// - High-set may be non-directional or a pure residual-voltage stage.
// - Low-set disable switch removes low-set start and trip.
// - Low-set and high-set start outputs and start indication code rise together.
// - Trip only if still started when operate time has elapsed.
// - Zero-degree angle sector 70 degrees below 3 percent setting, else 80.
// - Transient stage starts on a sudden voltage rise above trigger level.
// - Transient calculation and operate counter begin in the start cycle.
// - Transient trips only if voltage still above hold level at time-out.
// - Transient capacitive criterion is one third of the setting.
// - Integration window configurable, default 1.8 ms, passed to front end.
// - Low-set disable blocks high-set for 0.4 s after transient start.
// - Speed-up blocks both directional stages for about one second.
// - Calculation time 400 ms with low-set disabled and speed-up off.
// - With speed-up off and low-set enabled, directional trips suppressed between transient time minus 1 s and it.
// - Transient disable switch deactivates only the transient stage.
`timescale 1ns/1ps
`include "earth_fault_defines.svh"
module earth_fault_stages
    import earth_fault_pkg::*;
#(
    parameter int TICK_CYC = `EF_CLK_HZ / 1000 * `EF_TICK_MS
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    input wire meas_t i_meas,
    input wire logic [15:0] i_tr_ic_est,
    input wire logic i_tr_fwd,
    output stage_flags_t o_start,
    output stage_flags_t o_trip,
    output logic [1:0] o_start_code,
    output logic o_tr_calc_start,
    output logic o_tr_calc_active,
    output logic [15:0] o_integration_window
);
    localparam logic [15:0] HS_BLOCK = 16'(`EF_HS_BLOCK_MS / `EF_TICK_MS);
    localparam logic [15:0] SPD_BLOCK = 16'(`EF_SPEEDUP_BLOCK_MS / `EF_TICK_MS);
    localparam logic [15:0] TR_GUARD = 16'(`EF_TR_GUARD_MS / `EF_TICK_MS);
    localparam logic [15:0] MAX_MS = 16'hFFFF;

    logic [15:0] ctrl_r, ls_i_r, ls_u_r, ls_t_r, hs_i_r, hs_u_r, hs_t_r;
    logic [15:0] tr_trig_r, tr_hold_r, tr_ic_r, tr_t_r, int_r;
    logic [31:0] tick_cnt_r;
    logic tick;
    logic [15:0] ls_ms_r, hs_ms_r, tr_ms_r, uo_prev_r;
    tr_state_t tr_state_r;
    stage_flags_t start_r, trip_r;
    logic calc_start_r;
    logic lsdis, speedup, trdis, rev, tr_rise, ls_hit, hs_hit, ic_ok;
    logic ls_block, hs_block, guard, tr_time_up;
    charac_t ch;
    hs_mode_t hs_mode;
    logic [15:0] ic_third, calc_len;

    // Directional criterion for one stage
    function automatic logic dir_hit(input meas_t m, input charac_t c, input logic r,
                                     input logic [15:0] ithr, input logic [15:0] uthr);
        logic signed [9:0] p;
        logic signed [9:0] sec;
        logic signed [16:0] proj;
        logic signed [16:0] thr;
        logic u_ok;
        logic i_ok;
        p = m.phi;
        if (r) begin
            p = (m.phi > 10'sd0) ? (m.phi - 10'sd180) : (m.phi + 10'sd180);
        end
        sec = (ithr < 16'(`EF_SECTOR_LIMIT)) ? 10'sd`EF_SECTOR_NARROW
                                             : 10'sd`EF_SECTOR_WIDE;
        thr = signed'({1'b0, ithr});
        u_ok = m.uo_mag >= uthr;
        i_ok = m.io_mag >= ithr;
        proj = (c == CH_COS) ? 17'(m.io_cos) : -17'(m.io_sin);
        if (r) begin
            proj = -proj;
        end
        case (c)
            CH_ANG0: dir_hit = u_ok && i_ok && (p >= -sec) && (p <= sec);
            CH_ANG90: dir_hit = u_ok && i_ok && (p < 10'sd0) && (p > -10'sd180);
            CH_COS: dir_hit = u_ok && (proj >= thr);
            CH_SIN: dir_hit = u_ok && (proj >= thr);
            default: dir_hit = 1'b0;
        endcase
    endfunction

    assign lsdis = ctrl_r[`EF_CTRL_LSDIS];
    assign speedup = ctrl_r[`EF_CTRL_SPEEDUP];
    assign trdis = ctrl_r[`EF_CTRL_TRDIS];
    assign ch = charac_t'(ctrl_r[`EF_CTRL_CHAR_LO +: 2]);
    assign hs_mode = hs_mode_t'(ctrl_r[`EF_CTRL_HSMODE_LO +: 2]);
    assign rev = hs_mode == HS_REV;

    // Register port
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            ctrl_r <= `EF_CTRL_RESET;
            ls_i_r <= `EF_THR_RESET;
            ls_u_r <= `EF_THR_RESET;
            ls_t_r <= `EF_TIME_RESET;
            hs_i_r <= `EF_THR_RESET;
            hs_u_r <= `EF_THR_RESET;
            hs_t_r <= `EF_TIME_RESET;
            tr_trig_r <= `EF_THR_RESET;
            tr_hold_r <= `EF_THR_RESET;
            tr_ic_r <= `EF_THR_RESET;
            tr_t_r <= `EF_TR_TIME_RESET;
            int_r <= `EF_INT_RESET;
        end else if (i_wr) begin
            case (i_addr)
                `EF_ADDR_CTRL: ctrl_r <= {9'h000, i_wdata[6:0]};
                `EF_ADDR_LS_I: ls_i_r <= i_wdata;
                `EF_ADDR_LS_U: ls_u_r <= i_wdata;
                `EF_ADDR_LS_T: ls_t_r <= i_wdata;
                `EF_ADDR_HS_I: hs_i_r <= i_wdata;
                `EF_ADDR_HS_U: hs_u_r <= i_wdata;
                `EF_ADDR_HS_T: hs_t_r <= i_wdata;
                `EF_ADDR_TR_TRIG: tr_trig_r <= i_wdata;
                `EF_ADDR_TR_HOLD: tr_hold_r <= i_wdata;
                `EF_ADDR_TR_IC: tr_ic_r <= i_wdata;
                `EF_ADDR_TR_T: tr_t_r <= i_wdata;
                `EF_ADDR_TR_INT: int_r <= i_wdata;
                default: ctrl_r <= ctrl_r;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            case (i_addr)
                `EF_ADDR_CTRL: o_rdata <= ctrl_r;
                `EF_ADDR_LS_I: o_rdata <= ls_i_r;
                `EF_ADDR_LS_U: o_rdata <= ls_u_r;
                `EF_ADDR_LS_T: o_rdata <= ls_t_r;
                `EF_ADDR_HS_I: o_rdata <= hs_i_r;
                `EF_ADDR_HS_U: o_rdata <= hs_u_r;
                `EF_ADDR_HS_T: o_rdata <= hs_t_r;
                `EF_ADDR_TR_TRIG: o_rdata <= tr_trig_r;
                `EF_ADDR_TR_HOLD: o_rdata <= tr_hold_r;
                `EF_ADDR_TR_IC: o_rdata <= tr_ic_r;
                `EF_ADDR_TR_T: o_rdata <= tr_t_r;
                `EF_ADDR_TR_INT: o_rdata <= int_r;
                `EF_ADDR_STATUS: o_rdata <= {8'h00, o_tr_calc_active,
                                             hs_block, trip_r, start_r};
                default: o_rdata <= 16'h0000;
            endcase
        end else begin
            o_rdata <= 16'h0000;
        end
    end

    // Millisecond tick
    assign tick = tick_cnt_r == 32'(TICK_CYC - 1);
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b || tick) begin
            tick_cnt_r <= 32'h0000_0000;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
        end
    end

    // Start criteria
    assign ls_hit = !lsdis && dir_hit(i_meas, ch, 1'b0, ls_i_r, ls_u_r);
    always_comb begin
        case (hs_mode)
            HS_NONDIR: hs_hit = (i_meas.io_mag >= hs_i_r) && (i_meas.uo_mag >= hs_u_r);
            HS_VOLT: hs_hit = i_meas.uo_mag >= hs_u_r;
            default: hs_hit = dir_hit(i_meas, ch, rev, hs_i_r, hs_u_r);
        endcase
    end

    // Transient trigger and blocking windows
    assign tr_rise = !trdis && (uo_prev_r <= tr_trig_r)
                     && (i_meas.uo_mag > tr_trig_r);
    assign ic_third = tr_ic_r / 16'(`EF_IC_DIVISOR);
    assign ic_ok = (i_tr_ic_est >= ic_third) && i_tr_fwd;
    assign tr_time_up = tr_ms_r >= tr_t_r;
    assign calc_len = speedup ? SPD_BLOCK : (lsdis ? HS_BLOCK : tr_t_r);
    assign guard = (tr_t_r < TR_GUARD) || (tr_ms_r >= tr_t_r - TR_GUARD);
    always_comb begin
        ls_block = 1'b0;
        hs_block = 1'b0;
        if (tr_state_r == TR_RUN) begin
            if (speedup) begin
                ls_block = tr_ms_r < SPD_BLOCK;
                hs_block = tr_ms_r < SPD_BLOCK;
            end else if (lsdis) begin
                hs_block = tr_ms_r < HS_BLOCK;
            end else begin
                ls_block = guard && !tr_time_up;
                hs_block = guard && !tr_time_up;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            uo_prev_r <= 16'hFFFF;
        end else begin
            uo_prev_r <= i_meas.uo_mag;
        end
    end

    // Directional stage timers
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            start_r.ls <= 1'b0;
            start_r.hs <= 1'b0;
            trip_r.ls <= 1'b0;
            trip_r.hs <= 1'b0;
            ls_ms_r <= 16'h0000;
            hs_ms_r <= 16'h0000;
        end else begin
            start_r.ls <= ls_hit;
            start_r.hs <= hs_hit;
            ls_ms_r <= !ls_hit ? 16'h0000
                       : ((tick && ls_ms_r != MAX_MS) ? ls_ms_r + 16'h0001 : ls_ms_r);
            hs_ms_r <= !hs_hit ? 16'h0000
                       : ((tick && hs_ms_r != MAX_MS) ? hs_ms_r + 16'h0001 : hs_ms_r);
            trip_r.ls <= ls_hit && start_r.ls && (ls_ms_r >= ls_t_r) && !ls_block;
            trip_r.hs <= hs_hit && start_r.hs && (hs_ms_r >= hs_t_r) && !hs_block;
        end
    end

    // Transient stage sequence
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b || trdis) begin
            tr_state_r <= TR_IDLE;
            tr_ms_r <= 16'h0000;
            start_r.tr <= 1'b0;
            trip_r.tr <= 1'b0;
            calc_start_r <= 1'b0;
        end else begin
            calc_start_r <= 1'b0;
            case (tr_state_r)
                TR_IDLE: begin
                    if (tr_rise) begin
                        tr_state_r <= TR_RUN;
                        tr_ms_r <= 16'h0000;
                        start_r.tr <= 1'b1;
                        calc_start_r <= 1'b1;
                    end
                end
                TR_RUN: begin
                    if (tr_time_up) begin
                        start_r.tr <= 1'b0;
                        if ((i_meas.uo_mag > tr_hold_r) && ic_ok) begin
                            tr_state_r <= TR_TRIP;
                            trip_r.tr <= 1'b1;
                        end else begin
                            tr_state_r <= TR_IDLE;
                        end
                    end else if (tick) begin
                        tr_ms_r <= tr_ms_r + 16'h0001;
                    end
                end
                TR_TRIP: begin
                    if (i_meas.uo_mag <= tr_hold_r) begin
                        tr_state_r <= TR_IDLE;
                        trip_r.tr <= 1'b0;
                    end
                end
                default: tr_state_r <= TR_IDLE;
            endcase
        end
    end

    // Start indication code follows the highest started directional stage; transient start is not coded
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_start_code <= 2'h0;
        end else begin
            o_start_code <= (hs_hit ? 2'h2 : (ls_hit ? 2'h1 : 2'h0));
        end
    end

    assign o_start = start_r;
    assign o_trip = trip_r;
    assign o_tr_calc_start = calc_start_r;
    assign o_tr_calc_active = (tr_state_r == TR_RUN) && (tr_ms_r < calc_len);
    assign o_integration_window = int_r;

    sequence s_tr_begin;
        tr_state_r == TR_IDLE && tr_rise && !trdis;
    endsequence
    sequence s_tr_running;
        o_start.tr && o_tr_calc_start && tr_ms_r == 16'h0000;
    endsequence

    a_ls_disable_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        $past(lsdis) && lsdis |-> !o_start.ls && !o_trip.ls)
        else $error("low-set active while disabled");
    a_trip_needs_start: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        $rose(o_trip.ls) |-> o_start.ls && ls_ms_r >= ls_t_r)
        else $error("low-set trip without elapsed start");
    a_start_code_tracks: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        $rose(o_start.ls) && !o_start.hs |-> o_start_code == 2'h1)
        else $error("start code missing with start");
    a_tr_calc_begin: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        s_tr_begin |=> s_tr_running)
        else $error("transient start and calculation not together");
    a_hs_block_window: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        lsdis && !speedup && tr_state_r == TR_RUN && tr_ms_r < HS_BLOCK |=> !$rose(o_trip.hs))
        else $error("high-set tripped inside block window");
    a_speedup_block: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        speedup && tr_state_r == TR_RUN && tr_ms_r < SPD_BLOCK |=> !$rose(o_trip.ls))
        else $error("low-set tripped during speed-up block");
    a_start_drop_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !ls_hit |=> !o_start.ls && ls_ms_r == 16'h0000 ##1 !o_trip.ls)
        else $error("low-set not cleared after drop");
    a_tr_trip_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        $rose(o_trip.tr) |-> $past(i_meas.uo_mag) > tr_hold_r && $past(tr_time_up))
        else $error("transient trip without held voltage");
    a_tr_disable: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        trdis |=> !o_start.tr && !o_trip.tr)
        else $error("transient active while disabled");
endmodule
